// >>> src/tpc_pkg.sv
package tpc_pkg;
	// =====================================================================
	// register map (byte addresses)
	localparam logic [7:0] TPC_OFF_CTRL = 8'h00;
	localparam logic [7:0] TPC_OFF_POS = 8'h04;
	localparam logic [7:0] TPC_OFF_RECLEN = 8'h08;
	localparam logic [7:0] TPC_OFF_STATUS = 8'h0C;
	localparam logic [7:0] TPC_OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] TPC_OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] TPC_OFF_LED = 8'h18;
	localparam logic [7:0] TPC_OFF_POSTDLY_LO = 8'h1C;
	localparam logic [7:0] TPC_OFF_POSTDLY_HI = 8'h20;

	// =====================================================================
	// control register fields
	localparam int TPC_CTRL_ARM = 0;
	localparam int TPC_CTRL_MODE_LSB = 1;
	localparam int TPC_CTRL_SLOPE = 3;
	localparam int TPC_CTRL_WIN_ENTER = 4;
	localparam int TPC_CTRL_ACK = 5;

	// led override register fields
	localparam int TPC_LED_OVR = 0;
	localparam int TPC_LED_GREEN = 1;
	localparam int TPC_LED_RED = 2;

	// interrupt bits
	localparam int TPC_IRQ_TRIG = 0;
	localparam int TPC_IRQ_DONE = 1;
	localparam int TPC_IRQ_W = 2;

	// =====================================================================
	// reset values and sizes
	localparam logic [31:0] TPC_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TPC_POS_RST = 32'h0000_0000;
	localparam logic [31:0] TPC_RECLEN_RST = 32'h0000_0010;
	localparam int TPC_STEP_LOG2 = 4;
	localparam int TPC_DLY_W = 35;
	localparam int TPC_POS_W = 32;
	localparam int TPC_FAST_DIV = 4;
	localparam int TPC_FAST_CNT_W = 2;

	// spike stretcher: shortest pulse to catch and stretch length
	localparam real TPC_SPIKE_NS = 0.5;
	localparam real TPC_CLK_NS = 10.0;
	localparam int TPC_STRETCH_CYC = 2;

	typedef enum logic [1:0] {
		TPC_MODE_EDGE,
		TPC_MODE_WINDOW,
		TPC_MODE_FAST,
		TPC_MODE_SPIKE
	} tpc_mode_e;

	typedef enum {
		TPC_IDLE,
		TPC_ARMED,
		TPC_POST_WAIT,
		TPC_CAPTURE,
		TPC_DONE
	} tpc_state_e;
endpackage : tpc_pkg

// >>> src/tpc_sync.sv
`timescale 1ns/100ps
module tpc_sync #(
	parameter int WIDTH = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : tpc_sync

// >>> src/tpc_trig_pos.sv
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - window mode triggers on entering or leaving band
// - window trigger is OR of opposite edges
// - fast mode fires every fourth rising edge
// - fast mode excludes window triggering
// - spike mode stretches very short threshold pulses
// - spike mode forces rising-edge triggering
// - pre-trigger up to full record length
// - post-trigger delay counter is 35 bits
// - full pre-trigger puts trigger last
// - zero position stores from trigger onward
// - post delay waits before first sample
// - position steps are 16 samples
// - position signed: positive post, negative pre
// - led green while armed and waiting
// - led red when acquisition complete, unread
// - software may override led colour
// - positive slope rising, negative slope falling
// - trigger out from trigger until completion, not raised on full pre-trigger
module tpc_trig_pos
	import tpc_pkg::*;
#(
	parameter int REC_W = 24
) (
	input wire logic aclk,
	input wire logic aresetn,
	// comparator outputs from the trigger front end
	input wire logic cmp_level,
	input wire logic cmp_win_lo,
	input wire logic cmp_win_hi,
	// acquisition memory sequencer
	output logic acq_write_en,
	output logic acq_trig_mark,
	output logic trig_out,
	output logic led_green,
	output logic led_red,
	output logic irq,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// =====================================================================
	// registers
	logic [31:0] ctrl_q;
	logic [TPC_POS_W-1:0] pos_q;
	logic [31:0] reclen_q;
	logic [2:0] led_q;
	logic [TPC_IRQ_W-1:0] irq_stat_q;
	logic [TPC_IRQ_W-1:0] irq_mask_q;
	tpc_state_e state_q;
	logic [TPC_DLY_W-1:0] cnt_q;
	logic [TPC_FAST_CNT_W-1:0] fast_cnt_q;
	logic [TPC_STRETCH_CYC-1:0] stretch_q;
	logic [2:0] cmp_s;
	logic [2:0] cmp_prev_q;
	logic trig_ev;
	logic done_ev;
	tpc_mode_e mode;

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] wmerge(input logic [31:0] old,
			input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// =====================================================================
	// comparator synchronisers
	tpc_sync #(
		.WIDTH(3)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({cmp_win_hi, cmp_win_lo, cmp_level}),
		.sync_out(cmp_s)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_prev_q <= '0;
		end else begin
			cmp_prev_q <= cmp_s;
		end
	end

	// =====================================================================
	// trigger qualification
	// fast mode lives in the mode field, so window cannot coexist
	assign mode = tpc_mode_e'(ctrl_q[TPC_CTRL_MODE_LSB +: 2]);

	logic rise_lvl;
	logic fall_lvl;
	logic slope_ev;
	logic win_ev;
	logic enter_lo;
	logic leave_lo;
	logic enter_hi;
	logic leave_hi;
	logic fast_ev;
	logic spike_ev;
	logic qual_ev;

	assign rise_lvl = cmp_s[0] && !cmp_prev_q[0];
	assign fall_lvl = !cmp_s[0] && cmp_prev_q[0];
	// slope bit 0 = positive
	assign slope_ev = ctrl_q[TPC_CTRL_SLOPE] ? fall_lvl : rise_lvl;

	// low comparator high means above low threshold; high comparator high
	// means above high threshold; entering is rise over low or fall below
	// high, leaving the reverse pair
	assign enter_lo = cmp_s[1] && !cmp_prev_q[1];
	assign leave_lo = !cmp_s[1] && cmp_prev_q[1];
	assign enter_hi = !cmp_s[2] && cmp_prev_q[2];
	assign leave_hi = cmp_s[2] && !cmp_prev_q[2];
	assign win_ev = ctrl_q[TPC_CTRL_WIN_ENTER] ? (enter_lo || enter_hi)
		: (leave_lo || leave_hi);

	// every fourth rising edge, slope setting ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_cnt_q <= '0;
		end else if (mode != TPC_MODE_FAST) begin
			fast_cnt_q <= '0;
		end else if (rise_lvl) begin
			fast_cnt_q <= fast_cnt_q + 1'b1;
		end
	end
	assign fast_ev = rise_lvl
		&& (fast_cnt_q == TPC_FAST_CNT_W'(TPC_FAST_DIV - 1));

	// a sub-ns spike is invisible to a sampled level, so the stretcher
	// relies on the comparator latching; here the pulse is held for a few
	// clocks so a single-sample hit still makes one rising edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stretch_q <= '0;
		end else if (cmp_s[0]) begin
			stretch_q <= '1;
		end else begin
			stretch_q <= stretch_q >> 1;
		end
	end
	// rising edge only, slope bit ignored
	assign spike_ev = cmp_s[0] && !cmp_prev_q[0] && !stretch_q[0];

	always_comb begin
		case (mode)
			TPC_MODE_EDGE: qual_ev = slope_ev;
			TPC_MODE_WINDOW: qual_ev = win_ev;
			TPC_MODE_FAST: qual_ev = fast_ev;
			TPC_MODE_SPIKE: qual_ev = spike_ev;
			default: qual_ev = 1'b0;
		endcase
	end

	// =====================================================================
	// trigger position
	logic pos_neg;
	logic [TPC_POS_W-1:0] pos_mag_units;
	logic [TPC_DLY_W-1:0] post_samples;
	logic [TPC_DLY_W-1:0] pre_samples;
	logic [TPC_DLY_W-1:0] rec_samples;

	assign pos_neg = pos_q[TPC_POS_W-1];
	assign pos_mag_units = pos_neg ? (~pos_q + 1'b1) : pos_q;
	assign rec_samples = TPC_DLY_W'(reclen_q[REC_W-1:0]);
	// units of 16 samples, largest post delay just fits in 35 bits
	assign post_samples = TPC_DLY_W'({pos_mag_units, 4'h0});
	// pre amount never exceeds the record
	assign pre_samples = (TPC_DLY_W'({pos_mag_units, 4'h0}) > rec_samples)
		? rec_samples : TPC_DLY_W'({pos_mag_units, 4'h0});

	// =====================================================================
	// acquisition sequencer
	assign trig_ev = (state_q == TPC_ARMED) && qual_ev
		&& (!pos_neg || cnt_q >= pre_samples);
	assign done_ev = (state_q == TPC_CAPTURE) && (cnt_q == '0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= TPC_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				TPC_IDLE: begin
					cnt_q <= '0;
					if (ctrl_q[TPC_CTRL_ARM]) begin
						state_q <= TPC_ARMED;
					end
				end
				TPC_ARMED: begin
					// pre-fill counter saturates at pre amount
					if (pos_neg && cnt_q < pre_samples) begin
						cnt_q <= cnt_q + 1'b1;
					end
					if (trig_ev) begin
						if (!pos_neg && post_samples != '0) begin
							cnt_q <= post_samples - 1'b1;
							state_q <= TPC_POST_WAIT;
						end else if (rec_samples == pre_samples
								&& pos_neg) begin
							cnt_q <= '0;
							state_q <= TPC_DONE;
						end else begin
							// remaining samples after the trigger
							cnt_q <= rec_samples - pre_samples - 1'b1;
							state_q <= TPC_CAPTURE;
						end
					end
				end
				TPC_POST_WAIT: begin
					if (cnt_q == '0) begin
						cnt_q <= rec_samples - 1'b1;
						state_q <= TPC_CAPTURE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				TPC_CAPTURE: begin
					if (cnt_q == '0) begin
						state_q <= TPC_DONE;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				TPC_DONE: begin
					if (ctrl_q[TPC_CTRL_ACK]) begin
						state_q <= TPC_IDLE;
					end
				end
				default: state_q <= TPC_IDLE;
			endcase
		end
	end

	logic full_pre_trig;
	assign full_pre_trig = trig_ev && pos_neg && rec_samples == pre_samples;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acq_write_en <= 1'b0;
			acq_trig_mark <= 1'b0;
			trig_out <= 1'b0;
		end else begin
			// the trigger cycle itself stores the first sample at zero
			// position, and the last post-wait cycle stores it after a
			// delay; the closing zero count of capture only ends the record
			acq_write_en <= (state_q == TPC_ARMED && pos_neg)
				|| (trig_ev && (pos_neg || post_samples == '0))
				|| (state_q == TPC_POST_WAIT && cnt_q == '0)
				|| (state_q == TPC_CAPTURE && cnt_q != '0);
			acq_trig_mark <= trig_ev;
			if (trig_ev && !full_pre_trig) begin
				trig_out <= 1'b1;
			end else if (done_ev || full_pre_trig) begin
				trig_out <= 1'b0;
			end
		end
	end

	// =====================================================================
	// status indicator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_green <= 1'b0;
			led_red <= 1'b0;
		end else if (led_q[TPC_LED_OVR]) begin
			led_green <= led_q[TPC_LED_GREEN];
			led_red <= led_q[TPC_LED_RED];
		end else begin
			led_green <= state_q == TPC_ARMED;
			led_red <= state_q == TPC_DONE;
		end
	end

	// =====================================================================
	// axi4-lite slave; both channels accepted together, one cycle answer
	logic wr_go;
	logic rd_go;
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign wr_go = s_axi_awready;
	assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
	assign rd_go = s_axi_arready;

	logic wr_hit;
	always_comb begin
		case (s_axi_awaddr)
			TPC_OFF_CTRL, TPC_OFF_POS, TPC_OFF_RECLEN, TPC_OFF_STATUS,
			TPC_OFF_IRQ_STAT, TPC_OFF_IRQ_MASK, TPC_OFF_LED,
			TPC_OFF_POSTDLY_LO, TPC_OFF_POSTDLY_HI: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= TPC_CTRL_RST;
			pos_q <= TPC_POS_RST;
			reclen_q <= TPC_RECLEN_RST;
			led_q <= '0;
			irq_mask_q <= '0;
		end else begin
			// acknowledge is a one-shot strobe
			ctrl_q[TPC_CTRL_ACK] <= 1'b0;
			if (wr_go) begin
				case (s_axi_awaddr)
					TPC_OFF_CTRL: ctrl_q <= wmerge(ctrl_q, s_axi_wdata,
						s_axi_wstrb);
					TPC_OFF_POS: pos_q <= wmerge(pos_q, s_axi_wdata,
						s_axi_wstrb);
					TPC_OFF_RECLEN: reclen_q <= wmerge(reclen_q, s_axi_wdata,
						s_axi_wstrb);
					TPC_OFF_LED: led_q <= s_axi_wdata[2:0];
					TPC_OFF_IRQ_MASK: irq_mask_q <= s_axi_wdata[TPC_IRQ_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_go
				&& s_axi_awaddr == TPC_OFF_IRQ_STAT && s_axi_wstrb[0])
				? s_axi_wdata[TPC_IRQ_W-1:0] : '0))
				| {done_ev, trig_ev};
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= 2'b00;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				TPC_OFF_CTRL: s_axi_rdata <= ctrl_q;
				TPC_OFF_POS: s_axi_rdata <= pos_q;
				TPC_OFF_RECLEN: s_axi_rdata <= reclen_q;
				TPC_OFF_STATUS: s_axi_rdata <= {26'h0, trig_out,
					cmp_s, 2'(state_q == TPC_DONE ? 2'h2
					: state_q == TPC_IDLE ? 2'h0 : 2'h1)};
				TPC_OFF_IRQ_STAT: s_axi_rdata <= 32'(irq_stat_q);
				TPC_OFF_IRQ_MASK: s_axi_rdata <= 32'(irq_mask_q);
				TPC_OFF_LED: s_axi_rdata <= {29'h0, led_q};
				TPC_OFF_POSTDLY_LO: s_axi_rdata <= post_samples[31:0];
				TPC_OFF_POSTDLY_HI: s_axi_rdata <= {29'h0,
					post_samples[TPC_DLY_W-1:32]};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : tpc_trig_pos

// >>> verif/tpc_trig_pos_chk.sv
`timescale 1ns/100ps
// =============================================
// bus handshake and trigger pulse checks
module tpc_trig_pos_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic acq_trig_mark
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr_resp;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp)
		else $error("write not answered");
	property p_aw_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> s_axi_awready;
	endproperty
	a_aw_take: assert property (p_aw_take)
		else $error("write not taken");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	property p_rd_resp;
		s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp)
		else $error("read not answered");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped");
	property p_r_cause;
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid);
	endproperty
	a_r_cause: assert property (p_r_cause)
		else $error("read data without request");
	// unmapped offsets answer slave error with zero data
	property p_bad_addr;
		s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == 8'h24
			|=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
	endproperty
	a_bad_addr: assert property (p_bad_addr)
		else $error("unmapped read not refused");
	property p_mark_pulse;
		acq_trig_mark |=> !acq_trig_mark [*3];
	endproperty
	a_mark_pulse: assert property (p_mark_pulse)
		else $error("trigger mark not a single pulse");
	c_mark: cover property (acq_trig_mark);
	c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
	c_hold: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : tpc_trig_pos_chk

// >>> verif/tpc_front_model.sv
`timescale 1ns/100ps
// =============================================
// comparators and acquisition monitor
module tpc_front_model #(
	parameter int LO = 10,
	parameter int HI = 20,
	parameter int LVL = 15
) (
	input wire logic aclk,
	input wire logic [31:0] sig,
	output logic cmp_level,
	output logic cmp_win_lo,
	output logic cmp_win_hi,
	input wire logic acq_write_en,
	input wire logic acq_trig_mark,
	input wire logic trig_out,
	output int marks = 0,
	output int writes = 0,
	output int rises = 0,
	output int gap = 0
);
	logic to_q = 1'b0;
	logic wait_q = 1'b0;
	int cnt = 0;
	assign cmp_level = sig > LVL;
	assign cmp_win_lo = sig > LO;
	assign cmp_win_hi = sig > HI;
	// gap runs from the trigger mark to the first stored sample
	// counts update mid-cycle so the bench reads them free of races
	always @(negedge aclk) begin
		if (acq_trig_mark === 1'b1) begin
			marks++;
			cnt = 0;
			wait_q = 1'b1;
		end else if (wait_q)
			cnt++;
		if (acq_write_en === 1'b1) begin
			writes++;
			if (wait_q) begin
				gap = cnt;
				wait_q = 1'b0;
			end
		end
		if (trig_out === 1'b1 && to_q !== 1'b1)
			rises++;
		to_q = trig_out;
	end
endmodule : tpc_front_model

// >>> verif/tpc_trig_pos_tb_top.sv
`timescale 1ns/100ps
module tpc_trig_pos_tb_top
	import tpc_pkg::*;
;
	logic aclk, aresetn, cmp_level, cmp_win_lo, cmp_win_hi;
	logic acq_write_en, acq_trig_mark, trig_out, led_green, led_red, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] sig;
	int marks, writes, rises, gap, g0, dto, dw;
	int bad_count = 0;
	int check_count = 0;
	tpc_trig_pos tpc_trig_pos_inst (.aclk, .aresetn, .cmp_level,
		.cmp_win_lo, .cmp_win_hi, .acq_write_en, .acq_trig_mark, .trig_out,
		.led_green, .led_red, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	tpc_front_model tpc_front_model_inst (.aclk, .sig, .cmp_level,
		.cmp_win_lo, .cmp_win_hi, .acq_write_en, .acq_trig_mark,
		.trig_out, .marks, .writes, .rises, .gap);
	// =============================================
	// access tasks
	task automatic final_report();
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	// ready is raised late on purpose so the slave must hold its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = 2'b00);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		cyc(2);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk($sformatf("bresp %h", a), 32'(r), 32'(s_axi_bresp));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r = 2'b00);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		cyc(2);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk($sformatf("rdata %h", a), e, s_axi_rdata);
		chk($sformatf("rresp %h", a), 32'(r), 32'(s_axi_rresp));
	endtask : rd
	function automatic logic [31:0] cw(input tpc_mode_e md,
		input logic sl, en);
		return 32'h1 | (32'(md) << TPC_CTRL_MODE_LSB)
			| (32'(sl) << TPC_CTRL_SLOPE) | (32'(en) << TPC_CTRL_WIN_ENTER);
	endfunction : cw
	// arm, pulse the input np times, wait for completion, acknowledge
	task automatic acq(input logic [31:0] c, p, input int s0, s1, w, np,
		early);
		int m, t, n0;
		sig <= s0;
		wr(TPC_OFF_POS, p);
		m = marks;
		t = rises;
		n0 = writes;
		wr(TPC_OFF_CTRL, c);
		cyc(30);
		chk("green", 1, led_green);
		for (int i = 0; i < np; i++) begin
			sig <= s1;
			cyc(w);
			if (i < early)
				chk("early", m, marks);
			sig <= s0;
			cyc(6);
		end
		for (int i = 0; i < 400 && led_red !== 1'b1; i++)
			cyc(1);
		chk("red", 1, led_red);
		chk("marks", m + 1, marks);
		dto = rises - t;
		dw = writes - n0;
		wr(TPC_OFF_CTRL, 32'h1 << TPC_CTRL_ACK);
	endtask : acq
	// =============================================
	// clock, reset and sequence
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		#300000;
		bad_count++;
		final_report();
	end
	initial begin
		aresetn <= 1'b0;
		sig <= 0;
		s_axi_wstrb <= 4'hF;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} <= '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		cyc(4);
		aresetn <= 1'b1;
		rd(TPC_OFF_CTRL, TPC_CTRL_RST);
		rd(TPC_OFF_RECLEN, TPC_RECLEN_RST);
		rd(TPC_OFF_POS, TPC_POS_RST);
		rd(8'h24, 32'h0, 2'b10);
		wr(8'h24, 32'h0, 2'b10);
		wr(TPC_OFF_IRQ_MASK, 32'h3);
		acq(cw(TPC_MODE_EDGE, 0, 0), 0, 0, 30, 6, 1, 0);
		chk("writes", TPC_RECLEN_RST, dw);
		chk("trig_out", 1, dto);
		g0 = gap;
		chk("irq", 1, irq);
		rd(TPC_OFF_IRQ_STAT, 32'h3);
		wr(TPC_OFF_IRQ_MASK, 32'h0);
		chk("irq", 0, irq);
		wr(TPC_OFF_IRQ_MASK, 32'h3);
		wr(TPC_OFF_IRQ_STAT, 32'h1);
		rd(TPC_OFF_IRQ_STAT, 32'h2);
		wr(TPC_OFF_IRQ_STAT, 32'h2);
		chk("irq", 0, irq);
		acq(cw(TPC_MODE_EDGE, 0, 0), 2, 0, 30, 6, 1, 0);
		rd(TPC_OFF_POSTDLY_LO, 32'h20);
		chk("gap", 32, gap - g0);
		acq(cw(TPC_MODE_EDGE, 1, 0), 0, 0, 30, 6, 1, 1);
		acq(cw(TPC_MODE_SPIKE, 1, 0), 0, 0, 30, 1, 1, 0);
		acq(cw(TPC_MODE_SPIKE, 1, 0), 0, 30, 0, 6, 1, 1);
		acq(cw(TPC_MODE_FAST, 0, 1), 0, 0, 30, 3, 4, 3);
		acq(cw(TPC_MODE_WINDOW, 0, 1), 0, 0, 15, 6, 1, 0);
		acq(cw(TPC_MODE_WINDOW, 0, 1), 0, 30, 15, 6, 1, 0);
		acq(cw(TPC_MODE_WINDOW, 0, 0), 0, 0, 15, 6, 1, 1);
		acq(cw(TPC_MODE_EDGE, 0, 0), 32'hFFFF_FFFB, 0, 30, 6, 1, 0);
		chk("trig_out", 0, dto);
		wr(TPC_OFF_POS, 32'h7FFF_FFFF);
		rd(TPC_OFF_POSTDLY_LO, 32'hFFFF_FFF0);
		rd(TPC_OFF_POSTDLY_HI, 32'h7);
		wr(TPC_OFF_LED, 32'h5);
		cyc(2);
		chk("led red", 1, led_red);
		chk("led green", 0, led_green);
		wr(TPC_OFF_LED, 32'h3);
		cyc(2);
		chk("led red", 0, led_red);
		chk("led green", 1, led_green);
		sig <= 30;
		cyc(4);
		rd(TPC_OFF_STATUS, 32'h1C);
		final_report();
	end
endmodule : tpc_trig_pos_tb_top
bind tpc_trig_pos tpc_trig_pos_chk tpc_trig_pos_chk_inst (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.acq_trig_mark);
